/* hdl/serial_baud_clock_gen.sv */
// Serial transfer-clock generator: prescaler, baud divider, basic clock selection
// Contract
// RULE1: Geared source divided by four feeds six-bit prescaler as lowest tap.
// RULE2: Prescaler runs only while baud generator is the serial clock source.
// RULE3: Lowest tap is fc/4 at gear 0; gear halves; taps /4, /16, /64.
// RULE4: Software avoids lowest tap when prescaler source is fc/16 clock.
// RULE5: Two-bit input select picks one of four prescaler taps.
// RULE6: Fraction disabled: divide by integer N, fraction field ignored.
// RULE7: Divisor value zero divides by sixteen.
// RULE8: Fraction enabled: divide by N plus (16-K)/16. The code divides by N alone when K is 0.
// RULE9: Software clears fraction enable for N of 1 or 16.
// RULE10: Software clears fraction enable in synchronous shift mode.
// RULE11: Async rate is generator output over 16; sync rate over 2.
// RULE12: External clock: async rate over 16; sync rate equals external clock.
// RULE13: Timer match source gives async basic clock over 8; never sync.
// RULE14: Sync with clock output: generator output halved, driven on clock pin.
// RULE15: Sync with clock input: selected edge of pin forms basic clock.
// RULE16: Mode 0 synchronous; modes 1-3 asynchronous 7, 8, 9 bit.
// RULE17: Parity available in modes 1 and 2; mode 3 offers wake-up.
// RULE18: Channel has transmit, receive and shared clear-to-send/clock pins.
// RULE19: Async two-bit source field picks generator, sysclk, timer or pin.
`timescale 1ns/1ps
module serial_baud_clock_gen (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic [1:0] serial_mode,
   input wire logic [1:0] serial_clock_source,
   input wire logic [1:0] prescaler_source_sel,
   input wire logic [2:0] clock_gear_sel,
   input wire logic [1:0] baud_input_select,
   input wire logic fraction_add_enable,
   input wire logic [3:0] integer_divisor,
   input wire logic [3:0] fraction_k,
   input wire logic sclk_direction,
   input wire logic sclk_edge_select,
   input wire logic clear_to_send_enable,
   // Timer match pulse from timer zero
   input wire logic timer_match,
   // Shared clear-to-send / serial clock pin
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   // Basic clock, bit timing and clear-to-send status
   output logic basic_clk_pulse,
   output logic bit_clk_pulse,
   output logic clear_to_send_ok,
   // Mode capabilities
   output logic parity_allowed,
   output logic wakeup_allowed,
   output logic sync_mode
);
   logic is_sync, prescaler_run;
   logic [3:0] tap_pulse;
   logic pre_pulse;
   logic tap_sel_pulse;
   logic gen_pulse;
   // Three-stage pin synchroniser
   logic [2:0] pin_sync, next_pin_sync;
   logic pin_level, next_pin_level;
   logic pin_rise, pin_fall;
   // Timer match /8 and basic clock state
   logic [2:0] timer_cnt, next_timer_cnt;
   logic timer_base;
   logic sclk_half, next_sclk_half;
   logic basic, next_basic;
   logic [3:0] over_cnt, next_over_cnt;
   logic bit_pulse, next_bit_pulse;
   logic sclk_out, next_sclk_out;
   logic sclk_oe, next_sclk_oe;
   logic cts_ok, next_cts_ok;
   logic parity_ok, next_parity_ok;
   logic wake_ok, next_wake_ok;
   logic sync_q, next_sync_q;

   assign is_sync = (serial_mode == baud_clock_pkg::MODE_SYNC); // RULE16
   // Sync mode with clock input does not use the generator
   assign prescaler_run = is_sync ? !sclk_direction
      : (serial_clock_source == baud_clock_pkg::SRC_BAUD_GEN); // RULE2

   serial_prescaler #(
      .WIDTH(baud_clock_pkg::PRESCALER_BITS)
   ) u_prescaler (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(prescaler_run),
      .prescaler_source_sel(prescaler_source_sel),
      .clock_gear_sel(clock_gear_sel),
      .tap_pulse(tap_pulse),
      .pre_pulse(pre_pulse)
   );

   // Lowest tap under fc/16 source is left to software to avoid
   assign tap_sel_pulse = tap_pulse[baud_input_select]; // RULE5 RULE4

   baud_divider #(
      .DIV_BITS(4)
   ) u_divider (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_pulse(tap_sel_pulse),
      .fraction_add_enable(fraction_add_enable && !is_sync), // RULE10
      .integer_divisor(integer_divisor),
      .fraction_k(fraction_k),
      .out_pulse(gen_pulse)
   );

   always_comb begin
      next_pin_sync = {pin_sync[1:0], serial_clock_pin_in};
      // Change counts only once stages two and three agree
      next_pin_level = (pin_sync[2] == pin_sync[1]) ? pin_sync[2] : pin_level;
   end
   assign pin_rise = (pin_sync[2] == pin_sync[1]) && pin_sync[2] && !pin_level;
   assign pin_fall = (pin_sync[2] == pin_sync[1]) && !pin_sync[2] && pin_level;

   always_comb begin
      // Timer match divided by 8 forms the async basic clock
      timer_base = timer_match && (timer_cnt == baud_clock_pkg::TIMER_POST_DIV); // RULE13
      next_timer_cnt = timer_match ? timer_cnt + 3'h1 : timer_cnt;
      next_sclk_half = sclk_half;
      next_sclk_out = sclk_out;
      next_basic = 1'b0;
      next_sclk_oe = 1'b0;
      if (is_sync) begin
         next_timer_cnt = 3'h0; // RULE13
         if (!sclk_direction) begin
            next_sclk_oe = 1'b1; // RULE14
            if (gen_pulse) begin
               next_sclk_half = !sclk_half;
               next_sclk_out = !sclk_out;
               next_basic = sclk_half; // RULE14 RULE11
            end
         end else begin
            next_sclk_out = 1'b1;
            next_basic = sclk_edge_select ? pin_fall : pin_rise; // RULE15 RULE12
         end
      end else begin
         next_sclk_half = 1'b0;
         next_sclk_out = 1'b1;
         case (serial_clock_source) // RULE19
            baud_clock_pkg::SRC_BAUD_GEN: next_basic = gen_pulse;
            baud_clock_pkg::SRC_SYSCLK: next_basic = 1'b1;
            baud_clock_pkg::SRC_TIMER: next_basic = timer_base;
            baud_clock_pkg::SRC_EXT_PIN: next_basic = pin_rise;
            default: next_basic = 1'b0;
         endcase
      end
      // Bit pulse: every 16 basic clocks async, every basic clock sync
      next_over_cnt = over_cnt;
      next_bit_pulse = 1'b0;
      if (is_sync) begin
         next_over_cnt = 4'h0;
         next_bit_pulse = next_basic; // RULE12
      end else if (next_basic) begin
         next_over_cnt = over_cnt + 4'h1;
         next_bit_pulse = (over_cnt == baud_clock_pkg::OVERSAMPLE_LAST); // RULE11
      end
      // Shared pin serves clear-to-send in every mode, even while it carries a serial clock
      next_cts_ok = !clear_to_send_enable || !pin_level; // RULE18
      next_parity_ok = (serial_mode == baud_clock_pkg::MODE_UART7)
         || (serial_mode == baud_clock_pkg::MODE_UART8); // RULE17
      next_wake_ok = (serial_mode == baud_clock_pkg::MODE_UART9); // RULE17
      next_sync_q = is_sync; // RULE16
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pin_sync <= 3'h7;
         pin_level <= 1'b1;
         timer_cnt <= 3'h0;
         sclk_half <= 1'b0;
         sclk_out <= 1'b1;
         sclk_oe <= 1'b0;
         basic <= 1'b0;
         over_cnt <= 4'h0;
         bit_pulse <= 1'b0;
         cts_ok <= 1'b0;
         parity_ok <= 1'b0;
         wake_ok <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         pin_sync <= next_pin_sync;
         pin_level <= next_pin_level;
         timer_cnt <= next_timer_cnt;
         sclk_half <= next_sclk_half;
         sclk_out <= next_sclk_out;
         sclk_oe <= next_sclk_oe;
         basic <= next_basic;
         over_cnt <= next_over_cnt;
         bit_pulse <= next_bit_pulse;
         cts_ok <= next_cts_ok;
         parity_ok <= next_parity_ok;
         wake_ok <= next_wake_ok;
         sync_q <= next_sync_q;
      end
   end

   assign serial_clock_pin_out = sclk_out;
   assign serial_clock_pin_oe = sclk_oe;
   assign basic_clk_pulse = basic;
   assign bit_clk_pulse = bit_pulse;
   assign clear_to_send_ok = cts_ok;
   assign parity_allowed = parity_ok;
   assign wakeup_allowed = wake_ok;
   assign sync_mode = sync_q;

   // Checks
   sync_pin_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
      is_sync && !sclk_direction |=> serial_clock_pin_oe)
      else $error("clock pin not driven in sync output mode");
   pin_released_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE15
      (is_sync && sclk_direction) || !is_sync |=> !serial_clock_pin_oe)
      else $error("clock pin driven while not in output mode");
   prescaler_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
      !prescaler_run |-> tap_pulse == 4'h0)
      else $error("prescaler ran while not selected");
   timer_sync_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
      is_sync && sclk_direction && !pin_rise && !pin_fall |=> !basic_clk_pulse)
      else $error("sync basic clock without pin edge");
   taps_nested_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE3
      tap_pulse[3] |-> tap_pulse[2] && tap_pulse[1] && tap_pulse[0])
      else $error("upper tap fired without lower taps");
   tap_quarter_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE1
      tap_pulse[0] |-> pre_pulse)
      else $error("base tap without source pulse");
   mode_caps_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE17
      serial_mode == baud_clock_pkg::MODE_UART9 && $stable(serial_mode)
      |=> wakeup_allowed && !parity_allowed)
      else $error("mode three capabilities wrong");
   async_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
      !is_sync && $stable(serial_mode) && bit_clk_pulse |-> basic_clk_pulse)
      else $error("bit pulse without basic clock");
   sync_out_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
      is_sync && !sclk_direction && gen_pulse && !sclk_half |=> !basic_clk_pulse)
      else $error("basic clock not halved");
   sysclk_src_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE19
      !is_sync && serial_clock_source == baud_clock_pkg::SRC_SYSCLK |=> basic_clk_pulse)
      else $error("system clock source not selected");

   // Generator and source selection
   gen_on_tap_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
      gen_pulse |-> tap_sel_pulse)
      else $error("generator pulse without input tap");
   gen_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
      !prescaler_run |-> !gen_pulse)
      else $error("generator ran with prescaler stopped");
   gen_src_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE19
      !is_sync && serial_clock_source == baud_clock_pkg::SRC_BAUD_GEN
      |=> basic_clk_pulse == $past(gen_pulse))
      else $error("basic clock does not follow generator");
   timer_src_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
      !is_sync && serial_clock_source == baud_clock_pkg::SRC_TIMER
      |=> basic_clk_pulse == $past(timer_base))
      else $error("basic clock does not follow timer eighth");
   timer_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
      is_sync |=> timer_cnt == 3'h0)
      else $error("timer divider ran in shift mode");
   ext_src_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
      !is_sync && serial_clock_source == baud_clock_pkg::SRC_EXT_PIN
      |=> basic_clk_pulse == $past(pin_rise))
      else $error("basic clock does not follow pin rise");

   // Shift clock input and output
   sync_rise_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE15
      is_sync && sclk_direction && !sclk_edge_select |=> basic_clk_pulse == $past(pin_rise))
      else $error("rising pin edge not used");
   sync_fall_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE15
      is_sync && sclk_direction && sclk_edge_select |=> basic_clk_pulse == $past(pin_fall))
      else $error("falling pin edge not used");
   pin_edge_once_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE15
      pin_rise || pin_fall |=> !pin_rise && !pin_fall)
      else $error("pin edge reported twice");
   sclk_toggle_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
      is_sync && !sclk_direction && gen_pulse
      |=> serial_clock_pin_out != $past(serial_clock_pin_out))
      else $error("shift clock missed a generator pulse");
   sclk_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
      is_sync && !sclk_direction && !gen_pulse |=> $stable(serial_clock_pin_out))
      else $error("shift clock moved without generator pulse");
   sclk_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
      !is_sync |=> serial_clock_pin_out)
      else $error("shift clock not idle high");

   // Bit timing, handshake pin and mode flags
   sync_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
      is_sync |=> bit_clk_pulse == basic_clk_pulse)
      else $error("shift bit pulse differs from basic clock");
   async_last_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
      !is_sync && next_basic && over_cnt == baud_clock_pkg::OVERSAMPLE_LAST |=> bit_clk_pulse)
      else $error("sixteenth basic clock gave no bit pulse");
   async_gap_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
      !is_sync && !next_basic |=> !bit_clk_pulse)
      else $error("async bit pulse between basic clocks");
   cts_block_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE18
      clear_to_send_enable && pin_level |=> !clear_to_send_ok)
      else $error("send allowed while pin high");
   cts_free_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE18
      !clear_to_send_enable |=> clear_to_send_ok)
      else $error("send blocked with handshake off");
   sync_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE16
      1'b1 |=> sync_mode == $past(is_sync))
      else $error("sync mode flag wrong");
   parity_caps_a: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE17
      serial_mode == baud_clock_pkg::MODE_UART7 || serial_mode == baud_clock_pkg::MODE_UART8
      |=> parity_allowed && !wakeup_allowed)
      else $error("parity mode capabilities wrong");
endmodule : serial_baud_clock_gen

/* hdl/baud_clock_pkg.sv */
// Constants shared by the serial transfer-clock generator
package baud_clock_pkg;
   // Serial modes
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_UART7 = 2'h1;
   localparam logic [1:0] MODE_UART8 = 2'h2;
   localparam logic [1:0] MODE_UART9 = 2'h3;
   // Basic clock sources in asynchronous modes
   localparam logic [1:0] SRC_BAUD_GEN = 2'h0;
   localparam logic [1:0] SRC_SYSCLK = 2'h1;
   localparam logic [1:0] SRC_TIMER = 2'h2;
   localparam logic [1:0] SRC_EXT_PIN = 2'h3;
   // Prescaler source select
   localparam logic [1:0] PRE_SRC_GEARED = 2'h0;
   localparam logic [1:0] PRE_SRC_FC16 = 2'h2;
   // Tap select
   localparam logic [1:0] TAP_BASE = 2'h0;
   // Prescaler geometry and divider end counts
   localparam int PRESCALER_BITS = 6;
   localparam logic [1:0] PRE_INPUT_DIV = 2'h3;
   localparam logic [3:0] FC16_DIV = 4'hF;
   localparam logic [2:0] GEAR_MAX = 3'h4;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] FRACTION_STEPS = 4'hF;
   localparam logic [2:0] TIMER_POST_DIV = 3'h7;
endpackage : baud_clock_pkg

/* hdl/serial_prescaler.sv */
// Geared quarter divider and six-bit tap prescaler
`timescale 1ns/1ps
module serial_prescaler #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic [1:0] prescaler_source_sel,
   input wire logic [2:0] clock_gear_sel,
   // Tap pulses: base, div4, div16, div64
   output logic [3:0] tap_pulse,
   output logic pre_pulse
);
   if (WIDTH != 6) begin : g_width_check
      $error("prescaler width must be 6");
   end
   logic [3:0] gear_cnt, next_gear_cnt;
   logic [1:0] quarter_cnt, next_quarter_cnt;
   logic [WIDTH-1:0] pre_cnt, next_pre_cnt;
   logic src_pulse, base_pulse;
   logic [3:0] gear_last;
   always_comb begin
      // Gear steps beyond the top step saturate
      if (prescaler_source_sel == baud_clock_pkg::PRE_SRC_FC16) begin
         gear_last = baud_clock_pkg::FC16_DIV;
      end else if (clock_gear_sel > baud_clock_pkg::GEAR_MAX) begin
         gear_last = baud_clock_pkg::FC16_DIV;
      end else begin
         gear_last = 4'((5'h01 << clock_gear_sel) - 5'h01); // RULE3
      end
      src_pulse = (gear_cnt >= gear_last);
      base_pulse = src_pulse && (quarter_cnt == baud_clock_pkg::PRE_INPUT_DIV); // RULE1
      next_gear_cnt = src_pulse ? 4'h0 : gear_cnt + 4'h1;
      next_quarter_cnt = src_pulse ? quarter_cnt + 2'h1 : quarter_cnt;
      next_pre_cnt = base_pulse ? pre_cnt + 6'h01 : pre_cnt;
      if (!run) begin // RULE2
         next_gear_cnt = 4'h0;
         next_quarter_cnt = 2'h0;
         next_pre_cnt = '0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gear_cnt <= 4'h0;
         quarter_cnt <= 2'h0;
         pre_cnt <= '0;
      end else begin
         gear_cnt <= next_gear_cnt;
         quarter_cnt <= next_quarter_cnt;
         pre_cnt <= next_pre_cnt;
      end
   end
   // Taps fire when the lower bits roll over: /1, /4, /16, /64
   always_comb begin
      tap_pulse[0] = run && base_pulse;
      tap_pulse[1] = run && base_pulse && (pre_cnt[1:0] == 2'h3);
      tap_pulse[2] = run && base_pulse && (pre_cnt[3:0] == 4'hF);
      tap_pulse[3] = run && base_pulse && (pre_cnt[5:0] == 6'h3F); // RULE3
      pre_pulse = run && src_pulse;
   end
endmodule : serial_prescaler

/* hdl/baud_divider.sv */
// Integer and N+(16-K)/16 fractional divider, fraction for K of 1 to 15
`timescale 1ns/1ps
module baud_divider #(
   parameter int DIV_BITS = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Control
   input wire logic in_pulse,
   input wire logic fraction_add_enable,
   input wire logic [3:0] integer_divisor,
   input wire logic [3:0] fraction_k,
   // Divided output
   output logic out_pulse
);
   if (DIV_BITS != 4) begin : g_width_check
      $error("divisor width must be 4");
   end
   logic [4:0] cnt, next_cnt;
   logic [3:0] frac_acc, next_frac_acc;
   logic [4:0] n_eff;
   logic extra, next_extra;
   logic [4:0] frac_sum;
   always_comb begin
      n_eff = (integer_divisor == 4'h0) ? 5'h10 : {1'b0, integer_divisor}; // RULE7
      // Fraction accumulates 16-K per output; carry stretches one period
      frac_sum = {1'b0, frac_acc} + 5'h10 - {1'b0, fraction_k};
      next_cnt = cnt;
      next_frac_acc = frac_acc;
      next_extra = extra;
      out_pulse = 1'b0;
      if (in_pulse) begin
         if (cnt + 5'h01 >= n_eff + {4'h0, extra}) begin
            out_pulse = 1'b1;
            next_cnt = 5'h00;
            if (fraction_add_enable && fraction_k != 4'h0) begin // RULE8
               next_frac_acc = frac_sum[3:0];
               next_extra = frac_sum[4];
            end else begin // RULE6
               next_frac_acc = 4'h0;
               next_extra = 1'b0;
            end
         end else begin
            next_cnt = cnt + 5'h01;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt <= 5'h00;
         frac_acc <= 4'h0;
         extra <= 1'b0;
      end else begin
         cnt <= next_cnt;
         frac_acc <= next_frac_acc;
         extra <= next_extra;
      end
   end
endmodule : baud_divider

/* tb/serial_clock_peer.sv */
// Far-side peer on the shared clock pin: clock source or shift register
`timescale 1ns/1ps
module serial_clock_peer (
   // Clock
   input wire logic core_clk,
   // Peer behaviour
   input wire logic run,
   input wire logic [7:0] hi_cycles,
   input wire logic [7:0] lo_cycles,
   input wire logic rest_level,
   // Device side of the pin
   input wire logic pin_out,
   input wire logic pin_oe,
   // Resolved pin and received clock edges
   output logic pin_level,
   output logic [15:0] rise_count
);
   logic drive_val = 1'b1;
   logic last_level = 1'b1;
   logic [7:0] phase = 8'h00;
   initial rise_count = 16'h0000;
   // Peer lets go whenever the device drives the pin
   assign pin_level = pin_oe ? pin_out : drive_val;
   // Clock only while running; a steady level otherwise, never a stale edge
   always @(negedge core_clk) begin
      if (!run) begin
         drive_val <= rest_level;
         phase <= 8'h00;
      end else begin
         phase <= (phase == hi_cycles + lo_cycles - 8'h01) ? 8'h00 : phase + 8'h01;
         drive_val <= (phase < hi_cycles);
      end
   end
   // Shift register side counts the rising clock edges it receives
   always @(posedge core_clk) begin
      if (pin_oe && pin_level && !last_level) rise_count <= rise_count + 16'h0001;
      last_level <= pin_level;
   end
endmodule : serial_clock_peer

/* tb/serial_baud_clock_gen_tb_top.sv */
// Self-checking bench for the serial transfer-clock generator
`timescale 1ns/1ps
module serial_baud_clock_gen_tb_top;
   typedef struct {
      int mode, src, pre, tap, gear, frac, dir, n, k, tmr, ext, span;
   } row_t;
   row_t rows [17];
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] serial_mode = 2'h0;
   logic [1:0] serial_clock_source = 2'h0;
   logic [1:0] prescaler_source_sel = 2'h0;
   logic [2:0] clock_gear_sel = 3'h0;
   logic [1:0] baud_input_select = 2'h0;
   logic fraction_add_enable = 1'b0;
   logic [3:0] integer_divisor = 4'h1;
   logic [3:0] fraction_k = 4'h0;
   logic sclk_direction = 1'b0;
   logic sclk_edge_select = 1'b0;
   logic clear_to_send_enable = 1'b0;
   logic timer_match = 1'b0;
   logic peer_run = 1'b0;
   logic [7:0] peer_hi = 8'h05;
   logic [7:0] peer_lo = 8'h05;
   logic peer_rest = 1'b1;
   logic pin_level;
   logic [15:0] rise_count;
   logic serial_clock_pin_out;
   logic serial_clock_pin_oe;
   logic basic_clk_pulse;
   logic bit_clk_pulse;
   logic clear_to_send_ok;
   logic parity_allowed;
   logic wakeup_allowed;
   logic sync_mode;
   int num_errors = 0;
   int compares = 0;
   int tmr_per = 0;
   int tmr_cnt = 0;
   int since_rise = 0;
   logic prev_pin = 1'b1;

   serial_baud_clock_gen u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .serial_mode(serial_mode),
      .serial_clock_source(serial_clock_source), .prescaler_source_sel(prescaler_source_sel),
      .clock_gear_sel(clock_gear_sel), .baud_input_select(baud_input_select),
      .fraction_add_enable(fraction_add_enable), .integer_divisor(integer_divisor),
      .fraction_k(fraction_k), .sclk_direction(sclk_direction),
      .sclk_edge_select(sclk_edge_select), .clear_to_send_enable(clear_to_send_enable),
      .timer_match(timer_match), .serial_clock_pin_in(pin_level),
      .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
      .basic_clk_pulse(basic_clk_pulse), .bit_clk_pulse(bit_clk_pulse),
      .clear_to_send_ok(clear_to_send_ok), .parity_allowed(parity_allowed),
      .wakeup_allowed(wakeup_allowed), .sync_mode(sync_mode)
   );

   serial_clock_peer u_peer (
      .core_clk(core_clk), .run(peer_run), .hi_cycles(peer_hi), .lo_cycles(peer_lo),
      .rest_level(peer_rest), .pin_out(serial_clock_pin_out), .pin_oe(serial_clock_pin_oe),
      .pin_level(pin_level), .rise_count(rise_count)
   );

   always #25 core_clk = ~core_clk;

   // Timer zero stand-in: one match pulse every tmr_per cycles
   always @(negedge core_clk) begin
      tmr_cnt <= (tmr_cnt + 1 >= tmr_per) ? 0 : tmr_cnt + 1;
      timer_match <= (tmr_per != 0) && (tmr_cnt == 0);
   end

   // Age of the last rising pin edge, to tell which edge made a pulse
   always @(posedge core_clk) begin
      since_rise <= (pin_level && !prev_pin) ? 0 : since_rise + 1;
      prev_pin <= pin_level;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic wait_basic();
      int t;
      t = 0;
      do begin
         @(negedge core_clk);
         t++;
      end while (basic_clk_pulse !== 1'b1 && t < 20000);
      if (t >= 20000) begin
         num_errors++;
         $display("BAD at %0t: no basic clock pulse", $time);
         tally_and_finish();
      end
   endtask : wait_basic

   // Config is changed under reset so no old divider phase leaks in
   task automatic apply(input row_t r);
      @(negedge core_clk);
      sys_rst = 1'b1;
      serial_mode = 2'(r.mode);
      serial_clock_source = 2'(r.src);
      prescaler_source_sel = 2'(r.pre);
      baud_input_select = 2'(r.tap);
      clock_gear_sel = 3'(r.gear);
      fraction_add_enable = 1'(r.frac);
      sclk_direction = 1'(r.dir);
      integer_divisor = 4'(r.n);
      fraction_k = 4'(r.k);
      peer_run = (r.ext != 0);
      peer_hi = 8'(r.ext / 2);
      peer_lo = 8'(r.ext / 2);
      tmr_per = r.tmr;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : apply

   // Span of 16 basic pulses, with the bit pulses seen in it
   task automatic measure(output int cyc, output int bits, output int rises);
      int pulses;
      logic [15:0] r;
      cyc = 0;
      bits = 0;
      pulses = 0;
      wait_basic();
      wait_basic();
      // Peer counts a rise one cycle late, so the window starts here
      r = rise_count;
      while (pulses < 16 && cyc < 20000) begin
         @(negedge core_clk);
         cyc++;
         if (basic_clk_pulse === 1'b1) pulses++;
         if (bit_clk_pulse === 1'b1) bits++;
      end
      rises = int'(rise_count - r);
   endtask : measure

   initial begin
      int cyc;
      int bits;
      int rises;
      // mode src pre tap gear frac dir n k tmr ext span
      rows[0] = '{1, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 64};
      rows[1] = '{3, 0, 0, 1, 1, 0, 0, 3, 0, 0, 0, 1536};
      rows[2] = '{2, 0, 0, 0, 4, 0, 0, 2, 0, 0, 0, 2048};
      rows[3] = '{2, 0, 0, 0, 7, 0, 0, 1, 0, 0, 0, 1024};
      rows[4] = '{2, 0, 2, 1, 0, 0, 0, 1, 0, 0, 0, 4096};
      rows[5] = '{2, 0, 0, 2, 0, 0, 0, 1, 0, 0, 0, 1024};
      rows[6] = '{2, 0, 0, 3, 0, 0, 0, 1, 0, 0, 0, 4096};
      rows[7] = '{2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1024};
      rows[8] = '{2, 0, 0, 0, 0, 1, 0, 7, 3, 0, 0, 500};
      rows[9] = '{2, 0, 0, 0, 0, 0, 0, 5, 9, 0, 0, 320};
      rows[10] = '{2, 1, 0, 0, 0, 0, 0, 1, 0, 0, 0, 16};
      rows[11] = '{2, 2, 0, 0, 0, 0, 0, 1, 0, 3, 0, 384};
      rows[12] = '{2, 3, 0, 0, 0, 0, 0, 1, 0, 0, 10, 160};
      // Fraction and timer source both refused in shift mode
      rows[13] = '{0, 2, 0, 0, 0, 1, 0, 2, 5, 3, 0, 256};
      rows[14] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 12, 192};
      rows[15] = '{2, 0, 0, 0, 0, 1, 0, 2, 15, 0, 0, 132};
      rows[16] = '{2, 0, 0, 0, 0, 1, 0, 15, 1, 0, 0, 1020};
      repeat (19) @(negedge core_clk);
      check(serial_clock_pin_out, 1);
      check(serial_clock_pin_oe, 0);
      check(basic_clk_pulse, 0);
      check(sync_mode, 0);
      foreach (rows[i]) begin
         apply(rows[i]);
         check(parity_allowed, rows[i].mode == 1 || rows[i].mode == 2);
         check(wakeup_allowed, rows[i].mode == 3);
         check(sync_mode, rows[i].mode == 0);
         check(serial_clock_pin_oe, rows[i].mode == 0 && rows[i].dir == 0);
         measure(cyc, bits, rises);
         check(cyc, rows[i].span);
         check(bits, (rows[i].mode == 0) ? 16 : 1);
         check(rises, (rows[i].mode == 0 && rows[i].dir == 0) ? 16 : 0);
      end
      // Edge choice shows as the age of the rising edge at each pulse
      for (int e = 0; e < 2; e++) begin
         sclk_edge_select = 1'(e);
         apply(rows[14]);
         repeat (4) begin
            wait_basic();
            check(since_rise >= 7, e);
         end
      end
      sclk_edge_select = 1'b0;
      apply(rows[0]);
      for (int c = 0; c < 3; c++) begin
         @(negedge core_clk);
         clear_to_send_enable = (c != 0);
         peer_rest = (c != 2);
         repeat (6) @(negedge core_clk);
         check(clear_to_send_ok, c != 1);
      end
      tally_and_finish();
   end
endmodule : serial_baud_clock_gen_tb_top
